// ==== src/lock_status_pkg.sv ====
// Constants shared by the receiver lock and status monitor
package lock_status_pkg;
	// Register port addresses
	localparam logic [3:0] ADDR_STATUS   = 4'h0;
	localparam logic [3:0] ADDR_MASK     = 4'h1;
	localparam logic [3:0] ADDR_CONFIG   = 4'h2;
	localparam logic [3:0] ADDR_LOCKS    = 4'h3;
	localparam logic [3:0] ADDR_LOG_CNT  = 4'h4;
	localparam logic [3:0] ADDR_LOG_RD   = 4'h5;
	localparam logic [3:0] ADDR_PAR_CHK  = 4'h6;
	localparam logic [3:0] ADDR_INTERVAL = 4'h7;
	// Status event bits
	localparam int EV_LOCK_CHG = 0;
	localparam int EV_FAULT    = 1;
	localparam int EV_PARITY   = 2;
	localparam int EV_REPORT   = 3;
	localparam int EV_W        = 4;
	// Report interval, 1 s at 50 MHz
	localparam int CLK_HZ          = 50_000_000;
	localparam int INTERVAL_MS     = 1000;
	localparam int INTERVAL_CYCLES = CLK_HZ / 1000 * INTERVAL_MS;
	localparam int REC_WORDS       = 8;
	localparam int LOG_DEPTH       = 16;
	localparam int PAR_DEPTH       = 16;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// Encoded states in the report, plus the serial transmitter states
	typedef enum logic [1:0] {
		PN_SEARCH = 2'b00,
		PN_TRACK  = 2'b01,
		PN_LOSS   = 2'b10
	} pn_state_t;
	typedef enum logic [1:0] {
		FLL_OFF   = 2'b00,
		FLL_ACQ   = 2'b01,
		FLL_TRACK = 2'b10
	} fll_state_t;
	typedef enum logic [1:0] {
		CAR_ACQ   = 2'b00,
		CAR_TRACK = 2'b01,
		CAR_LOSS  = 2'b10
	} car_state_t;
	typedef enum logic [1:0] {
		MODE_ACQ   = 2'b00,
		MODE_DEMOD = 2'b01,
		MODE_REACQ = 2'b10
	} rx_mode_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOAD = 2'b01,
		TX_SEND = 2'b10
	} tx_state_t;
endpackage : lock_status_pkg

// ==== src/receiver_lock_status_monitor.sv ====
// Receiver lock indicators, serial status report, fault log and memory parity check
//Contract
//- Carrier lock indicator high while carrier locked, low otherwise.
//- Code lock indicator follows spreading code lock state.
//- Combined indicator high only when code and carrier locks both high.
//- Bit synchronizer lock indicator follows bit sync lock state.
//- Decoder lock indicator shows decoder branch synchronization.
//- Status record sent serially to GPIB side at bounded interval.
//- Record holds code despreading state: searching, tracking, loss of lock.
//- Record holds frequency loop off, or on acquiring or tracking.
//- Record holds carrier loop state: acquisition, tracking, loss of lock.
//- Record holds despread, equalizer and IF filter bandwidth configuration flags.
//- Record holds operating mode: acquisition, demodulation, reacquisition.
//- Record holds error rates, SNR and both gain control levels.
//- Detected malfunction written into memory for later maintenance readout.
//- Parity bits computed over memory contents and mismatch flagged.
//- Test access points expose code search flag and carrier oscillator.
`timescale 1ns/1ps
module receiver_lock_status_monitor
	import lock_status_pkg::*;
#(
	parameter int REPORT_CYCLES = INTERVAL_CYCLES
)(
	input  wire logic        clock_in,           // 50 MHz system clock
	input  wire logic        rst_in,             // Synchronous reset, high
	input  wire logic        carrier_locked_in,  // Carrier loop lock, async
	input  wire logic        code_locked_in,     // Code loop lock, async
	input  wire logic        bitsync_locked_in,  // Bit sync lock, async
	input  wire logic        decoder_locked_in,  // Decoder branch sync, async
	input  wire logic [1:0]  pn_state_in,        // Despreading state
	input  wire logic [1:0]  fll_state_in,       // Frequency loop state
	input  wire logic [1:0]  car_state_in,       // Carrier loop state
	input  wire logic [1:0]  rx_mode_in,         // Receiver mode
	input  wire logic        despread_en_in,     // Despreading enabled
	input  wire logic        equalizer_en_in,    // Equalizer enabled
	input  wire logic [3:0]  if_bw_sel_in,       // IF filter bandwidths
	input  wire logic [15:0] ser_est_in,         // Symbol error rate
	input  wire logic [15:0] ber_est_in,         // Bit error rate
	input  wire logic [15:0] snr_est_in,         // SNR estimate
	input  wire logic [15:0] ncagc_in,           // Noncoherent gain level
	input  wire logic [15:0] cagc_in,            // Coherent gain level
	input  wire logic        fault_in,           // Malfunction pulse
	input  wire logic [15:0] fault_code_in,      // Malfunction description
	input  wire logic        code_search_in,     // Code search flag
	input  wire logic [15:0] carrier_nco_in,     // Carrier oscillator phase
	input  wire logic [3:0]  addr_in,            // Register address
	input  wire logic [31:0] wdata_in,           // Write data
	input  wire logic        wr_in,              // Write strobe
	input  wire logic        rd_in,              // Read strobe
	output logic      [31:0] rdata_out,          // Read data
	output logic             irq_out,            // Interrupt level
	output logic             carrier_lock_ind_out,  // Carrier lock indicator
	output logic             code_lock_ind_out,     // Code lock indicator
	output logic             combined_lock_ind_out, // Code and carrier lock
	output logic             bitsync_lock_ind_out,  // Bit sync lock indicator
	output logic             decoder_lock_ind_out,  // Decoder lock indicator
	output logic             ser_data_out,       // Serial status bit
	output logic             ser_valid_out,      // Serial bit valid
	output logic             ser_frame_out,      // First bit of record
	output logic             tp_code_search_out, // Test point
	output logic      [15:0] tp_carrier_nco_out  // Test point
);
	// Two-stage synchronisers for the lock levels
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end
		else
		begin
			sync1 <= {decoder_locked_in, bitsync_locked_in, code_locked_in, carrier_locked_in};
			sync2 <= sync1;
		end
	end

	logic [3:0] lock_q;
	logic       comb_q;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			lock_q <= 4'h0;
			comb_q <= 1'b0;
		end
		else
		begin
			lock_q <= sync2;
			comb_q <= sync2[0] & sync2[1];
		end
	end
	assign carrier_lock_ind_out  = lock_q[0];
	assign code_lock_ind_out     = lock_q[1];
	assign combined_lock_ind_out = comb_q;
	assign bitsync_lock_ind_out  = lock_q[2];
	assign decoder_lock_ind_out  = lock_q[3];

	// test points, registered to keep data outputs off logic paths
	logic [1:0]  srch_sync;
	logic [15:0] nco_q;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			srch_sync <= 2'b00;
			nco_q     <= 16'h0000;
		end
		else
		begin
			srch_sync <= {srch_sync[0], code_search_in};
			nco_q     <= carrier_nco_in;
		end
	end
	assign tp_code_search_out = srch_sync[1];
	assign tp_carrier_nco_out = nco_q;

	// Register decode
	wire wr_mask  = wr_in && (addr_in == ADDR_MASK);
	wire wr_cfg   = wr_in && (addr_in == ADDR_CONFIG);
	wire wr_par   = wr_in && (addr_in == ADDR_PAR_CHK);
	wire wr_intv  = wr_in && (addr_in == ADDR_INTERVAL);
	wire rd_stat  = rd_in && (addr_in == ADDR_STATUS);
	wire rd_log   = rd_in && (addr_in == ADDR_LOG_RD);

	logic [EV_W-1:0] status;
	logic [EV_W-1:0] mask;
	logic            report_en;
	logic [31:0]     interval;
	logic [EV_W-1:0] events;

	logic [15:0] log_mem [LOG_DEPTH];
	logic [4:0]  log_cnt;
	logic [3:0]  log_wp;
	logic [3:0]  log_rp;
	always_ff @(posedge clock_in)
	begin
		if (fault_in)
			log_mem[log_wp] <= fault_code_in;
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			log_wp  <= 4'h0;
			log_rp  <= 4'h0;
			log_cnt <= 5'h00;
		end
		else
		begin
			if (fault_in)
				log_wp <= log_wp + 4'h1;
			if (rd_log)
				log_rp <= log_rp + 4'h1;
			if (fault_in && log_cnt != 5'h10)
				log_cnt <= log_cnt + 5'h01;
		end
	end

	// parity memory: software writes words, engine checks stored parity
	logic [31:0] par_mem [PAR_DEPTH];
	logic [3:0]  par_ptr;
	logic        par_err;
	wire  [31:0] par_word  = par_mem[par_ptr];
	wire         par_calc  = ^par_word[30:0];
	// Write data bit 31 stores inverted parity so the self test can prove detection
	wire         par_store_bit = ^wdata_in[23:0] ^ wdata_in[31];
	always_ff @(posedge clock_in)
	begin
		if (wr_par)
			par_mem[wdata_in[27:24]] <= {par_store_bit, 7'h00, wdata_in[23:0]};
	end
	logic [PAR_DEPTH-1:0] par_valid;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			par_ptr   <= 4'h0;
			par_err   <= 1'b0;
			par_valid <= '0;
		end
		else
		begin
			par_ptr <= par_ptr + 4'h1;
			if (wr_par)
				par_valid[wdata_in[27:24]] <= 1'b1;
			par_err <= par_valid[par_ptr] && (par_calc != par_word[31]);
		end
	end

	logic [31:0] tick_cnt;
	wire         tick = report_en && (tick_cnt >= interval);
	always_ff @(posedge clock_in)
	begin
		if (rst_in || tick)
			tick_cnt <= ZERO32;
		else if (report_en)
			tick_cnt <= tick_cnt + 32'h0000_0001;
	end

	logic [15:0] record [REC_WORDS];
	logic [15:0] snap   [REC_WORDS];
	always_comb
	begin
		record[0] = {lock_q, comb_q, 1'b0, rx_mode_in, car_state_in, fll_state_in, pn_state_in, 2'b00};
		record[1] = {8'h00, if_bw_sel_in, 2'b00, equalizer_en_in, despread_en_in};
		record[2] = ser_est_in;
		record[3] = ber_est_in;
		record[4] = snr_est_in;
		record[5] = ncagc_in;
		record[6] = cagc_in;
		record[7] = {11'h000, log_cnt};
	end

	tx_state_t   tx_state;
	logic [2:0]  word_idx;
	logic [3:0]  bit_idx;
	logic        done_pulse;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			tx_state      <= TX_IDLE;
			word_idx      <= 3'h0;
			bit_idx       <= 4'h0;
			ser_data_out  <= 1'b0;
			ser_valid_out <= 1'b0;
			ser_frame_out <= 1'b0;
			done_pulse    <= 1'b0;
		end
		else
		begin
			done_pulse    <= 1'b0;
			ser_frame_out <= 1'b0;
			case (tx_state)
				TX_IDLE:
				begin
					ser_valid_out <= 1'b0;
					if (tick)
						tx_state <= TX_LOAD;
				end
				TX_LOAD:
				begin
					for (int i = 0; i < REC_WORDS; i++)
						snap[i] <= record[i];
					word_idx <= 3'h0;
					bit_idx  <= 4'hF;
					tx_state <= TX_SEND;
				end
				TX_SEND:
				begin
					ser_valid_out <= 1'b1;
					ser_data_out  <= snap[word_idx][bit_idx];
					ser_frame_out <= (word_idx == 3'h0) && (bit_idx == 4'hF);
					bit_idx       <= bit_idx - 4'h1;
					if (bit_idx == 4'h0)
					begin
						word_idx <= word_idx + 3'h1;
						if (word_idx == 3'h7)
						begin
							tx_state   <= TX_IDLE;
							done_pulse <= 1'b1;
						end
					end
				end
				default:
					tx_state <= TX_IDLE;
			endcase
		end
	end

	// Event capture; a new event wins over the read clear
	logic [3:0] lock_prev;
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			lock_prev <= 4'h0;
		else
			lock_prev <= lock_q;
	end
	always_comb
	begin
		events              = '0;
		events[EV_LOCK_CHG] = (lock_prev != lock_q);
		events[EV_FAULT]    = fault_in;
		events[EV_PARITY]   = par_err;
		events[EV_REPORT]   = done_pulse;
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			status    <= '0;
			mask      <= '0;
			report_en <= 1'b1;
			interval  <= 32'(REPORT_CYCLES - 1);
		end
		else
		begin
			status <= (rd_stat ? '0 : status) | events;
			if (wr_mask)
				mask <= wdata_in[EV_W-1:0];
			if (wr_cfg)
				report_en <= wdata_in[0];
			if (wr_intv)
				interval <= wdata_in;
		end
	end
	assign irq_out = |(status & mask);

	// Read mux
	logic [31:0] rd_mux;
	always_comb
	begin
		case (addr_in)
			ADDR_STATUS:   rd_mux = {28'h0, status};
			ADDR_MASK:     rd_mux = {28'h0, mask};
			ADDR_CONFIG:   rd_mux = {31'h0, report_en};
			ADDR_LOCKS:    rd_mux = {27'h0, comb_q, lock_q};
			ADDR_LOG_CNT:  rd_mux = {27'h0, log_cnt};
			ADDR_LOG_RD:   rd_mux = {16'h0, log_mem[log_rp]};
			ADDR_INTERVAL: rd_mux = interval;
			default:       rd_mux = ZERO32;
		endcase
	end
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			rdata_out <= ZERO32;
		else if (rd_in)
			rdata_out <= rd_mux;
		else
			rdata_out <= ZERO32;
	end

	// Assertions
	// Pin to indicator is two synchroniser stages plus the indicator register
	sequence s_sync_run;
		!rst_in ##1 !rst_in ##1 !rst_in;
	endsequence
	AST_COMB: assert property (@(posedge clock_in) disable iff (rst_in)
		combined_lock_ind_out == (carrier_lock_ind_out && code_lock_ind_out))
		else $error("combined lock differs from carrier and code locks");
	AST_CAR: assert property (@(posedge clock_in) disable iff (rst_in)
		s_sync_run |=> carrier_lock_ind_out == $past(carrier_locked_in, 3))
		else $error("carrier indicator mismatch");
	AST_CODE: assert property (@(posedge clock_in) disable iff (rst_in)
		s_sync_run |=> code_lock_ind_out == $past(code_locked_in, 3))
		else $error("code indicator mismatch");
	AST_BIT: assert property (@(posedge clock_in) disable iff (rst_in)
		s_sync_run |=> bitsync_lock_ind_out == $past(bitsync_locked_in, 3))
		else $error("bit sync indicator mismatch");
	AST_DEC: assert property (@(posedge clock_in) disable iff (rst_in)
		s_sync_run |=> decoder_lock_ind_out == $past(decoder_locked_in, 3))
		else $error("decoder indicator mismatch");
	AST_RST: assert property (@(posedge clock_in)
		$past(rst_in) |-> !carrier_lock_ind_out && !code_lock_ind_out && !combined_lock_ind_out
			&& !bitsync_lock_ind_out && !decoder_lock_ind_out)
		else $error("indicator not cleared by reset");
	sequence s_frame;
		ser_frame_out && ser_valid_out;
	endsequence
	AST_FRAME: assert property (@(posedge clock_in) disable iff (rst_in)
		s_frame |=> ser_valid_out [*8])
		else $error("record bits interrupted");
	AST_LOG: assert property (@(posedge clock_in) disable iff (rst_in)
		fault_in && log_cnt != 5'h10 |=> log_cnt == $past(log_cnt) + 5'h01)
		else $error("fault not logged");
	AST_IRQ: assert property (@(posedge clock_in) disable iff (rst_in)
		par_err && mask[EV_PARITY] |=> irq_out)
		else $error("parity error not signalled");
endmodule : receiver_lock_status_monitor

// ==== tb/status_sink.sv ====
// Ground station side model that collects the serial status record
`timescale 1ns/1ps
module status_sink (
	input  wire logic         clock_in,     // System clock
	input  wire logic         rst_in,       // Synchronous reset, high
	input  wire logic         ser_data_in,  // Serial status bit
	input  wire logic         ser_valid_in, // Bit valid
	input  wire logic         ser_frame_in, // First bit of record
	output logic      [127:0] rec_out,      // Last complete record
	output int                rec_n_out,    // Records received
	output logic              gap_out       // Valid dropped inside a record
);
	logic [127:0] shreg;
	int           nbits;
	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			nbits = 0;
			rec_n_out <= 0;
			gap_out <= 1'b0;
		end
		else if (ser_valid_in)
		begin
			shreg = ser_frame_in ? {127'h0, ser_data_in} : {shreg[126:0], ser_data_in};
			nbits = ser_frame_in ? 1 : nbits + 1;
			if (nbits == 128)
			begin
				rec_out <= shreg;
				rec_n_out <= rec_n_out + 1;
			end
		end
		else if (nbits inside {[1:127]})
			gap_out <= 1'b1;
	end
endmodule : status_sink

// ==== tb/tb_top.sv ====
// Self-checking bench for the receiver lock and status monitor
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
	import lock_status_pkg::*;
	logic clock_in, rst_in, carrier_locked_in, code_locked_in, bitsync_locked_in;
	logic decoder_locked_in, despread_en_in, equalizer_en_in, fault_in, code_search_in;
	logic wr_in, rd_in, irq_out, carrier_lock_ind_out, code_lock_ind_out, combined_lock_ind_out;
	logic bitsync_lock_ind_out, decoder_lock_ind_out, ser_data_out, ser_valid_out, ser_frame_out;
	logic         tp_code_search_out, gap;
	logic [1:0]   pn_state_in, fll_state_in, car_state_in, rx_mode_in;
	logic [3:0]   if_bw_sel_in, addr_in;
	logic [15:0]  ser_est_in, ber_est_in, snr_est_in, ncagc_in, cagc_in;
	logic [15:0]  fault_code_in, carrier_nco_in, tp_carrier_nco_out, v;
	logic [31:0]  wdata_in, rdata_out, d;
	logic [127:0] rec;
	int           rec_n, n0, err_count, checks, cyc, cnt;
	logic [15:0]  exp_log[$];

	receiver_lock_status_monitor #(.REPORT_CYCLES(200)) dut_u (.*);
	status_sink sink_u (.clock_in, .rst_in, .ser_data_in(ser_data_out),
		.ser_valid_in(ser_valid_out), .ser_frame_in(ser_frame_out), .rec_out(rec),
		.rec_n_out(rec_n), .gap_out(gap));

	always #10 clock_in = ~clock_in;

	// Hang guard, well above the planned run length
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] x);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= x;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] x);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 x = rdata_out;
	endtask : rd_reg

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask : wait_cyc

	initial
	begin
		{clock_in, carrier_locked_in, code_locked_in, bitsync_locked_in, decoder_locked_in,
			despread_en_in, equalizer_en_in, fault_in, code_search_in, wr_in, rd_in,
			pn_state_in, fll_state_in, car_state_in, rx_mode_in, if_bw_sel_in, addr_in,
			ser_est_in, ber_est_in, snr_est_in, ncagc_in, cagc_in, fault_code_in,
			carrier_nco_in, wdata_in} = '0;
		rst_in = 1'b1;
		void'($urandom(20));
		repeat (10) @(posedge clock_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clock_in);
			{decoder_locked_in, bitsync_locked_in, code_locked_in, carrier_locked_in} <= i[3:0];
			wait_cyc(5);
			`CHK(carrier_lock_ind_out, i[0])
			`CHK(code_lock_ind_out, i[1])
			`CHK(combined_lock_ind_out, i[0] & i[1])
			`CHK(bitsync_lock_ind_out, i[2])
			`CHK(decoder_lock_ind_out, i[3])
			rd_reg(ADDR_LOCKS, d);
			`CHK(d[4:0], {i[0] & i[1], i[3:0]})
		end
		$display("lock indicator test done");
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clock_in);
			pn_state_in <= 2'($urandom_range(2));
			fll_state_in <= 2'($urandom_range(2));
			car_state_in <= 2'($urandom_range(2));
			rx_mode_in <= 2'($urandom_range(2));
			{despread_en_in, equalizer_en_in, if_bw_sel_in} <= 6'($urandom);
			{ser_est_in, ber_est_in, snr_est_in, ncagc_in, cagc_in} <= 80'({$urandom, $urandom,
				$urandom});
			n0 = rec_n;
			for (int t = 0; t < 1000 && rec_n < n0 + 2; t++)
				wait_cyc(1);
			`CHK(rec_n >= n0 + 2, 1'b1)
			`CHK(gap, 1'b0)
			`CHK(rec[127:122], 6'b111110)
			`CHK(rec[115:112], {pn_state_in, 2'b00})
			`CHK(rec[117:116], fll_state_in)
			`CHK(rec[119:118], car_state_in)
			`CHK(rec[121:120], rx_mode_in)
			`CHK(rec[111:96], {8'h00, if_bw_sel_in, 2'b00, equalizer_en_in, despread_en_in})
			`CHK(rec[95:16], {ser_est_in, ber_est_in, snr_est_in, ncagc_in, cagc_in})
		end
		$display("status record test done");
		wr_reg(ADDR_MASK, 32'h0000_0002);
		rd_reg(ADDR_STATUS, d);
		// Back-to-back malfunction pulses each make one entry
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clock_in);
			v = 16'($urandom);
			fault_in <= 1'b1;
			fault_code_in <= v;
			exp_log.push_back(v);
		end
		@(posedge clock_in);
		fault_in <= 1'b0;
		wait_cyc(2);
		`CHK(irq_out, 1'b1)
		rd_reg(ADDR_STATUS, d);
		`CHK(d[EV_FAULT], 1'b1)
		`CHK(irq_out, 1'b0)
		rd_reg(ADDR_LOG_CNT, d);
		`CHK(d, 32'h0000_0003)
		while (exp_log.size() > 0)
		begin
			rd_reg(ADDR_LOG_RD, d);
			`CHK(d[15:0], exp_log.pop_front())
		end
		$display("fault log test done");
		for (int k = 0; k < 16; k++)
			wr_reg(ADDR_PAR_CHK, {4'h0, 4'(k), 24'($urandom)});
		wait_cyc(40);
		rd_reg(ADDR_STATUS, d);
		`CHK(d[EV_PARITY], 1'b0)
		// Word 5 stored with inverted parity must be caught by the scan
		wr_reg(ADDR_MASK, 32'h0000_0004);
		wr_reg(ADDR_PAR_CHK, {4'h8, 4'h5, 24'($urandom)});
		wait_cyc(20);
		`CHK(irq_out, 1'b1)
		rd_reg(ADDR_STATUS, d);
		`CHK(d[EV_PARITY], 1'b1)
		wr_reg(ADDR_PAR_CHK, {4'h0, 4'h5, 24'($urandom)});
		wait_cyc(20);
		rd_reg(ADDR_STATUS, d);
		wait_cyc(20);
		`CHK(irq_out, 1'b0)
		$display("parity test done");
		rd_reg(4'hF, d);
		`CHK(d, ZERO32)
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clock_in);
			v = 16'($urandom);
			carrier_nco_in <= v;
			code_search_in <= v[0];
			wait_cyc(1);
			`CHK(tp_carrier_nco_out, v)
			wait_cyc(2);
			`CHK(tp_code_search_out, v[0])
		end
		rd_reg(ADDR_INTERVAL, d);
		`CHK(d, 32'h0000_00C7)
		wr_reg(ADDR_INTERVAL, 32'h0000_012B);
		rd_reg(ADDR_INTERVAL, d);
		`CHK(d, 32'h0000_012B)
		// Records complete one interval apart once the new interval runs
		n0 = rec_n;
		while (rec_n == n0)
			wait_cyc(1);
		n0 = rec_n;
		cnt = 0;
		while (rec_n == n0)
		begin
			wait_cyc(1);
			cnt++;
		end
		`CHK(cnt, 300)
		`CHK(rec[15:0], 16'h0003)
		wr_reg(ADDR_CONFIG, 32'h0000_0000);
		wait_cyc(150);
		n0 = rec_n;
		wait_cyc(600);
		`CHK(rec_n, n0)
		$display("test point and enable test done");
		give_verdict();
	end
endmodule : tb_top
